//--- verilog/itw_pkg.sv
// Constants and types for the interval timer and watchdog block
package itw_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte addresses
  localparam logic [7:0] ADDR_INTERVAL = 8'hEC;
  localparam logic [7:0] ADDR_PERIOD   = 8'hF0;
  localparam logic [7:0] ADDR_STATUS   = 8'hF4;
  localparam logic [7:0] ADDR_CTL_RB   = 8'hF8;

  // Control register fields
  localparam int CTL_SEL_LSB = 0;
  localparam int CTL_SEL_W   = 3;
  localparam int CTL_ICLR    = 3;
  localparam int CTL_RCSEL   = 4;
  localparam int CTL_WDEN    = 5;
  localparam int CTL_WAKE    = 6;
  localparam logic [7:0] CTL_RESET  = 8'h00;
  localparam logic [7:0] CTL_WMASK  = 8'h7F;

  // Watchdog period register fields
  localparam int PER_CLR = 7;
  localparam int PER_W   = 7;

  // Status register fields
  localparam int ST_IFLAG = 0;
  localparam int ST_GFLAG = 1;

  // Prescaler: smallest divide is 2**3, wake tap is divide 2048
  localparam int          PRE_W     = 11;
  localparam logic [3:0]  WAKE_SEL  = 4'h8;
  localparam logic [11:0] DIV_BASE  = 12'h008;
  localparam logic [11:0] ONE_12    = 12'h001;
  localparam logic [7:0]  IVAL_TOP  = 8'hFF;
  localparam logic [7:0]  RC_HALF   = 8'h80;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int RST_PULSE_NS  = 640;
  localparam int RST_PULSE_CYC =
    (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 8;

  typedef enum logic [3:0] {
    MODE_RUN  = 4'b0001,
    MODE_STOP = 4'b0010,
    MODE_WAKE = 4'b0100,
    MODE_RC   = 4'b1000
  } mode_t;

endpackage

//--- verilog/interval_timer_watchdog.sv
// Interval timer with watchdog, AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module interval_timer_watchdog
  import itw_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              stop_req,
  input  wire logic              sub_clock_mode,
  input  wire logic              rc_osc_clk,
  output logic                   interval_irq_flag,
  output logic                   guard_irq_flag,
  output logic                   guard_reset_req,
  output logic                   reset_pin_out,
  output logic                   reset_pin_oe,
  output logic                   main_osc_on,
  output logic                   wake_tick,
  output logic [3:0]             power_mode
);

  function automatic logic tap_hit(input logic [PRE_W-1:0] pre,
                                   input logic [3:0]       sel);
    logic [PRE_W-1:0] m;
    m = PRE_W'((DIV_BASE << sel) - ONE_12);
    return (pre & m) == m;
  endfunction

  logic [7:0]           ctl_reg;
  logic [PRE_W-1:0]     pre_reg;
  logic [7:0]           ival_reg;
  logic [PER_W-1:0]     period_reg;
  logic                 wclr_reg;
  logic [PER_W-1:0]     wd_reg;
  logic                 armed_reg;
  logic                 wd_step_reg;
  logic                 pending_reg;
  logic                 iflag_reg;
  logic                 gflag_reg;
  logic [RST_CNT_W-1:0] rst_cnt_reg;
  logic                 osc_on_reg;
  logic                 wake_reg;
  logic                 rc_s1_reg;
  logic                 rc_s2_reg;
  logic                 rc_s3_reg;
  mode_t                mode_reg;
  mode_t                mode_next;
  logic                 aw_full_reg;
  logic [ADDR_W-1:0]    aw_addr_reg;
  logic                 w_full_reg;
  logic [DATA_W-1:0]    w_data_reg;
  logic [3:0]           w_strb_reg;
  logic                 bvalid_reg;
  logic [1:0]           bresp_reg;
  logic                 rvalid_reg;
  logic [DATA_W-1:0]    rdata_reg;
  logic [1:0]           rresp_reg;
  logic                 wr_go;
  logic                 wr_ctl;
  logic                 wr_per;
  logic                 wr_st;
  logic                 ival_clr;
  logic                 rc_edge;
  logic                 pre_tick;
  logic                 ival_step;
  logic                 ival_ovf;
  logic                 wd_step;
  logic                 wd_match;
  logic                 fire;
  logic                 fire_rst;
  logic [DATA_W-1:0]    rd_mux;
  logic                 rd_hit;

  // Bus write side: address and data held separately, either order
  assign awready = !aw_full_reg;
  assign wready  = !w_full_reg;
  assign wr_go   = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_ctl  = wr_go && aw_addr_reg == ADDR_INTERVAL && w_strb_reg[0];
  assign wr_per  = wr_go && aw_addr_reg == ADDR_PERIOD && w_strb_reg[0];
  assign wr_st   = wr_go && aw_addr_reg == ADDR_STATUS && w_strb_reg[0];
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (awvalid && !aw_full_reg) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end else if (wr_go) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (wvalid && !w_full_reg) begin
      w_full_reg <= 1'b1;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end else if (wr_go) begin
      w_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (aw_addr_reg == ADDR_INTERVAL ||
                     aw_addr_reg == ADDR_PERIOD ||
                     aw_addr_reg == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Bus read side
  // shared address
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (araddr)
      ADDR_INTERVAL: rd_mux[7:0] = ival_reg;
      ADDR_PERIOD:   rd_mux[7:0] = {wclr_reg, period_reg};
      ADDR_STATUS:   rd_mux[ST_GFLAG:ST_IFLAG] = {gflag_reg, iflag_reg};
      ADDR_CTL_RB:   rd_mux[11:0] = {mode_reg, ctl_reg};
      default:       rd_hit = 1'b0;
    endcase
  end

  assign arready = !rvalid_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else if (arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Control register; clear bit drops one cycle after it is written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_reg <= CTL_RESET;
    end else if (wr_ctl) begin
      ctl_reg <= w_data_reg[7:0] & CTL_WMASK;
    end else begin
      ctl_reg[CTL_ICLR] <= 1'b0;
    end
  end

  assign ival_clr = wr_ctl && w_data_reg[CTL_ICLR];

  // Power mode follows the core's STOP level
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      MODE_RUN: begin
        if (stop_req && ctl_reg[CTL_RCSEL])
          mode_next = MODE_RC;
        else if (stop_req && ctl_reg[CTL_WAKE])
          mode_next = MODE_WAKE;
        else if (stop_req)
          mode_next = MODE_STOP;
      end
      MODE_STOP, MODE_WAKE, MODE_RC: begin
        if (!stop_req)
          mode_next = MODE_RUN;
      end
      default: mode_next = MODE_RUN;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      mode_reg <= MODE_RUN;
    else
      mode_reg <= mode_next;
  end

  assign power_mode = mode_reg;

  // RC clock is foreign: two flops, then edge detect past them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc_s1_reg <= 1'b0;
      rc_s2_reg <= 1'b0;
      rc_s3_reg <= 1'b0;
    end else begin
      rc_s1_reg <= rc_osc_clk;
      rc_s2_reg <= rc_s1_reg;
      rc_s3_reg <= rc_s2_reg;
    end
  end

  assign rc_edge = rc_s2_reg && !rc_s3_reg;

  // Prescaler runs whenever the main oscillator would
  always_ff @(posedge aclk) begin
    if (!aresetn)
      pre_reg <= '0;
    else if (mode_reg == MODE_RUN || mode_reg == MODE_WAKE)
      pre_reg <= pre_reg + PRE_W'(1);
  end

  assign pre_tick = tap_hit(pre_reg, {1'b0, ctl_reg[CTL_SEL_W-1:0]});

  assign ival_step = (mode_reg == MODE_RUN && pre_tick) ||
                     (mode_reg == MODE_RC && rc_edge);
  assign ival_ovf  = ival_step && ival_reg == IVAL_TOP;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      wake_reg <= 1'b0;
    else
      wake_reg <= mode_reg == MODE_WAKE && tap_hit(pre_reg, WAKE_SEL);
  end

  assign wake_tick = wake_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      ival_reg <= '0;
    else if (ival_clr)
      ival_reg <= '0;
    else if (ival_step)
      ival_reg <= ival_reg + 8'h01;
  end

  // Set wins over a same-cycle status clear
  always_ff @(posedge aclk) begin
    if (!aresetn)
      iflag_reg <= 1'b0;
    else if (ival_ovf)
      iflag_reg <= 1'b1;
    else if (wr_st && w_data_reg[ST_IFLAG])
      iflag_reg <= 1'b0;
  end

  assign interval_irq_flag = iflag_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      armed_reg <= 1'b0;
    else if (ival_clr)
      armed_reg <= 1'b1;
  end

  // Watchdog period register and its self-clearing clear bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_reg <= '0;
      wclr_reg   <= 1'b0;
    end else if (wr_per) begin
      period_reg <= w_data_reg[PER_W-1:0];
      wclr_reg   <= w_data_reg[PER_CLR];
    end else begin
      wclr_reg <= 1'b0;
    end
  end

  // one step per overflow, held in plain STOP
  assign wd_step  = armed_reg && ival_ovf && !ival_clr;
  assign wd_match = wd_reg == period_reg;

  // Outside RC, fire just after a step, or at count 0x80 if an RC timeout is still pending; a zero period fires when the count wraps after 128 steps
  assign fire = (mode_reg != MODE_RC && wd_step_reg && wd_match) ||
                (pending_reg && ival_reg == RC_HALF);
  assign fire_rst = fire && ctl_reg[CTL_WDEN];

  always_ff @(posedge aclk) begin
    if (!aresetn)
      wd_reg <= '0;
    else if (wr_per && w_data_reg[PER_CLR])
      wd_reg <= '0;
    else if (fire)
      wd_reg <= '0;
    else if (wd_step)
      wd_reg <= wd_reg + PER_W'(1);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      wd_step_reg <= 1'b0;
    else
      wd_step_reg <= wd_step;
  end

  // RC timeout adds half an interval
  always_ff @(posedge aclk) begin
    if (!aresetn)
      pending_reg <= 1'b0;
    else if (fire || (wr_per && w_data_reg[PER_CLR]))
      pending_reg <= 1'b0;
    else if (mode_reg == MODE_RC && wd_step_reg && wd_match)
      pending_reg <= 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      gflag_reg <= 1'b0;
    else if (fire && !ctl_reg[CTL_WDEN])
      gflag_reg <= 1'b1;
    else if (wr_st && w_data_reg[ST_GFLAG])
      gflag_reg <= 1'b0;
  end

  assign guard_irq_flag = gflag_reg;

  // reset pin pulled low for a fixed time
  always_ff @(posedge aclk) begin
    if (!aresetn)
      rst_cnt_reg <= '0;
    else if (fire_rst)
      rst_cnt_reg <= RST_CNT_W'(RST_PULSE_CYC);
    else if (rst_cnt_reg != '0)
      rst_cnt_reg <= rst_cnt_reg - RST_CNT_W'(1);
  end

  assign guard_reset_req = rst_cnt_reg != '0;
  assign reset_pin_oe    = rst_cnt_reg != '0;
  assign reset_pin_out   = 1'b0;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      osc_on_reg <= 1'b0;
    else
      osc_on_reg <= fire_rst && sub_clock_mode;
  end

  assign main_osc_on = osc_on_reg;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_wrap_flag;
    ival_ovf |=> iflag_reg && ival_reg == 8'h00;
  endproperty
  a_wrap_flag: assert property (p_wrap_flag)
    else $error("wrap did not set interval flag");

  property p_div8;
    (mode_reg == MODE_RUN && ctl_reg[2:0] == 3'h0 && pre_tick && !wr_ctl)
      |=> !pre_tick [*7];
  endproperty
  a_div8: assert property (p_div8)
    else $error("divide by 8 ticks too often");

  property p_free_step;
    (ival_step && !ival_clr) |=> ival_reg == $past(ival_reg) + 8'h01;
  endproperty
  a_free_step: assert property (p_free_step)
    else $error("interval counter missed a step");

  property p_iclr;
    ival_clr |=> ival_reg == 8'h00 ##1 !ctl_reg[CTL_ICLR];
  endproperty
  a_iclr: assert property (p_iclr)
    else $error("interval clear misbehaved");

  property p_wd_reset;
    fire_rst |=> reset_pin_oe [*8];
  endproperty
  a_wd_reset: assert property (p_wd_reset)
    else $error("reset pin not held low");

  property p_wd_irq;
    (fire && !ctl_reg[CTL_WDEN]) |=> gflag_reg && !reset_pin_oe;
  endproperty
  a_wd_irq: assert property (p_wd_irq)
    else $error("watchdog flag not set");

  property p_wclr;
    (wr_per && w_data_reg[PER_CLR]) |=> wd_reg == '0 ##1 !wclr_reg;
  endproperty
  a_wclr: assert property (p_wclr)
    else $error("watchdog clear misbehaved");

  property p_unarmed;
    !armed_reg |=> wd_reg == '0 || $stable(wd_reg);
  endproperty
  a_unarmed: assert property (p_unarmed)
    else $error("watchdog counted before arming");

  property p_stop_hold;
    (mode_reg == MODE_STOP && !wr_per) |=> $stable(wd_reg);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("watchdog moved in stop");

  property p_reset_zero;
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> ctl_reg == 8'h00 && wd_reg == '0 && ival_reg == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("reset left state nonzero");

  property p_osc_on;
    (fire_rst && sub_clock_mode) |=> main_osc_on;
  endproperty
  a_osc_on: assert property (p_osc_on)
    else $error("main oscillator not restarted");

  c_wd_reset: cover property (fire_rst);
  c_wd_irq:   cover property (fire && !ctl_reg[CTL_WDEN]);
  c_ival_irq: cover property (ival_ovf);
  c_rc_fire:  cover property (pending_reg ##1 fire);

endmodule // interval_timer_watchdog

`default_nettype wire

//--- test/interval_timer_watchdog_test.sv
// Self-checking testbench for the interval timer and watchdog block
`timescale 1ns/1ps
`default_nettype none

module interval_timer_watchdog_test;
  import itw_pkg::*;

  logic              aclk;
  logic              aresetn;
  logic [ADDR_W-1:0] awaddr;
  logic              awvalid;
  logic              awready;
  logic [DATA_W-1:0] wdata;
  logic [3:0]        wstrb;
  logic              wvalid;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready;
  logic [ADDR_W-1:0] araddr;
  logic              arvalid;
  logic              arready;
  logic [DATA_W-1:0] rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready;
  logic              stop_req;
  logic              sub_clock_mode;
  logic              rc_osc_clk;
  logic              interval_irq_flag;
  logic              guard_irq_flag;
  logic              guard_reset_req;
  logic              reset_pin_out;
  logic              reset_pin_oe;
  logic              main_osc_on;
  logic              wake_tick;
  logic [3:0]        power_mode;
  int                n_mismatch;
  int                num_checks;

  interval_timer_watchdog i_interval_timer_watchdog (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .stop_req(stop_req), .sub_clock_mode(sub_clock_mode),
    .rc_osc_clk(rc_osc_clk), .interval_irq_flag(interval_irq_flag),
    .guard_irq_flag(guard_irq_flag), .guard_reset_req(guard_reset_req),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .main_osc_on(main_osc_on), .wake_tick(wake_tick),
    .power_mode(power_mode)
  );

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp,
                          input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // X never lands inside the range
  task automatic check_in(input logic [31:0] got, input int lo, input int hi,
                          input string what);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: got %0d outside %0d..%0d", $time, what,
               got, lo, hi);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    r = bresp;
    bready <= 1'b0;
    check_in(n, 1, 99, "write answer");
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    check_in(n, 1, 99, "read answer");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check_eq(r, RESP_OKAY, "write resp");
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_read(a, d, r);
    check_eq(r, RESP_OKAY, "read resp");
  endtask

  task automatic t_reset();
    logic [31:0] d;
    rd(ADDR_CTL_RB, d);
    check_eq(d, {20'h0_0000, MODE_RUN, CTL_RESET}, "ctl at reset");
    rd(ADDR_INTERVAL, d);
    check_in(d, 0, 3, "count at reset");
    check_eq({interval_irq_flag, guard_irq_flag, reset_pin_oe}, 0, "flags");
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(8'h40, d, r);
    check_eq(r, RESP_SLVERR, "unmapped read resp");
    check_eq(d, 32'h0000_0000, "unmapped read data");
    axi_write(8'h40, 32'h0000_00FF, r);
    check_eq(r, RESP_SLVERR, "unmapped write");
    // Byte lane 0 off: register must keep its value
    wstrb <= 4'h0;
    axi_write(ADDR_PERIOD, 32'h0000_0005, r);
    wstrb <= 4'hF;
    check_eq(r, RESP_OKAY, "strobe-less write resp");
    rd(ADDR_PERIOD, d);
    check_eq(d, 32'h0000_0000, "write without strobe");
  endtask

  // Each code doubles the step time; clear restarts from zero
  task automatic t_divide();
    logic [31:0] d;
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_INTERVAL, 32'h0000_0008 | c);
      rd(ADDR_CTL_RB, d);
      check_eq(d, {20'h0_0000, MODE_RUN, 8'(c)}, "clear self-clears");
      tick((8 << c) * 4);
      rd(ADDR_INTERVAL, d);
      check_in(d, 3, 5, "steps after four periods");
    end
  endtask

  task automatic t_overflow();
    logic [31:0] d;
    wr(ADDR_INTERVAL, 32'h0000_0008);
    wr(ADDR_STATUS, 32'h0000_0003);
    tick(1900);
    check_eq(interval_irq_flag, 1'b0, "flag before wrap");
    tick(300);
    check_eq(interval_irq_flag, 1'b1, "flag after wrap");
    rd(ADDR_STATUS, d);
    check_eq(d[ST_IFLAG], 1'b1, "status flag");
    wr(ADDR_STATUS, 32'h0000_0001);
    check_eq(interval_irq_flag, 1'b0, "flag cleared");
  endtask

  task automatic t_guard_irq();
    logic [31:0] d;
    wr(ADDR_PERIOD, 32'h0000_0082);
    wr(ADDR_INTERVAL, 32'h0000_0008);
    wr(ADDR_STATUS, 32'h0000_0003);
    // Kicks come faster than two overflows
    repeat (4) begin
      tick(1500);
      wr(ADDR_PERIOD, 32'h0000_0082);
    end
    tick(1500);
    check_eq(guard_irq_flag, 1'b0, "no fire while kicked");
    tick(3000);
    check_eq({guard_irq_flag, reset_pin_oe}, 2'b10, "guard fires");
    rd(ADDR_PERIOD, d);
    check_eq(d, 32'h0000_0002, "period readback");
    rd(ADDR_STATUS, d);
    check_eq(d[ST_GFLAG], 1'b1, "guard status");
    wr(ADDR_STATUS, 32'h0000_0002);
    check_eq(guard_irq_flag, 1'b0, "guard flag cleared");
  endtask

  task automatic t_guard_reset();
    logic [31:0] d;
    logic        osc;
    int          n;
    osc = 1'b0;
    n = 0;
    sub_clock_mode <= 1'b1;
    wr(ADDR_PERIOD, 32'h0000_0081);
    // Flag left set by the RC scenario
    wr(ADDR_STATUS, 32'h0000_0003);
    wr(ADDR_INTERVAL, 32'h0000_0028);
    while (reset_pin_oe !== 1'b1 && n < 6000) begin
      @(posedge aclk);
      osc |= main_osc_on;
      n++;
    end
    check_eq({reset_pin_out, guard_reset_req}, 2'b01, "reset pin");
    n = 0;
    while (reset_pin_oe === 1'b1 && n < 100) begin
      @(posedge aclk);
      osc |= main_osc_on;
      n++;
    end
    check_eq(n, RST_PULSE_CYC, "reset pulse length");
    check_eq({osc, guard_irq_flag}, 2'b10, "osc restart");
    sub_clock_mode <= 1'b0;
    aresetn <= 1'b0;
    tick(2);
    aresetn <= 1'b1;
    tick(1);
    rd(ADDR_CTL_RB, d);
    check_eq(d, {20'h0_0000, MODE_RUN, CTL_RESET}, "enable after reset");
  endtask

  task automatic t_stop_wake();
    logic [31:0] a;
    logic [31:0] b;
    int          n;
    wr(ADDR_INTERVAL, 32'h0000_0000);
    stop_req <= 1'b1;
    tick(2);
    check_eq(power_mode, MODE_STOP, "stop mode");
    rd(ADDR_INTERVAL, a);
    tick(200);
    rd(ADDR_INTERVAL, b);
    check_eq(b, a, "count holds in stop");
    stop_req <= 1'b0;
    tick(2);
    check_eq(power_mode, MODE_RUN, "back to run");
    wr(ADDR_INTERVAL, 32'h0000_0040);
    stop_req <= 1'b1;
    tick(2);
    check_eq(power_mode, MODE_WAKE, "wake mode");
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (wake_tick !== 1'b1 && n < 3000);
    end
    check_eq(n, 2048, "wake tick spacing");
    stop_req <= 1'b0;
    tick(2);
  endtask

  // RC clock runs only while the block sits in RC stop
  task automatic t_rc();
    int n;
    n = 0;
    wr(ADDR_PERIOD, 32'h0000_0081);
    wr(ADDR_INTERVAL, 32'h0000_0018);
    wr(ADDR_STATUS, 32'h0000_0003);
    stop_req <= 1'b1;
    tick(2);
    check_eq(power_mode, MODE_RC, "rc mode");
    while (guard_irq_flag !== 1'b1 && n < 500) begin
      rc_osc_clk <= 1'b1;
      tick(4);
      rc_osc_clk <= 1'b0;
      tick(4);
      n++;
    end
    check_in(n, 370, 392, "rc timeout edges");
    stop_req <= 1'b0;
    tick(2);
    check_eq(power_mode, MODE_RUN, "leave rc");
  endtask

  initial begin
    aresetn = 1'b0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    stop_req = 1'b0;
    sub_clock_mode = 1'b0;
    rc_osc_clk = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    tick(5);
    aresetn <= 1'b1;
    tick(1);
    t_reset();
    t_unmapped();
    t_divide();
    t_overflow();
    t_guard_irq();
    t_stop_wake();
    t_rc();
    t_guard_reset();
    stop_test();
  end

  // Whole run needs about 31k cycles; limit leaves margin
  initial begin
    #(60_000 * CLK_PERIOD_NS);
    n_mismatch++;
    $display("[FAIL] %0t run timed out", $time);
    stop_test();
  end

endmodule // interval_timer_watchdog_test

`default_nettype wire
